// >>> design/pfsw_pkg.sv
// Package for the program flash self-write controller.
// Assumes a single instruction clock and a synchronous reset.
package pfsw_pkg;
	localparam int          PFSW_DATA_W      = 14;
	localparam int          PFSW_ADDR_W      = 15;
	localparam int          PFSW_LATCHES     = 16;
	localparam int          PFSW_LATCH_SEL_W = 4;
	localparam int          PFSW_ROW_LSB     = 5;
	localparam logic [13:0] PFSW_BLANK_WORD  = 14'h3fff;
	localparam logic [7:0]  PFSW_UNLOCK_1    = 8'h55;
	localparam logic [7:0]  PFSW_UNLOCK_2    = 8'haa;
	localparam logic [14:0] PFSW_CFG_BASE    = 15'h2000;
	localparam logic [14:0] PFSW_UID_LAST    = 15'h2003;
	localparam logic [14:0] PFSW_DEVID_ADDR  = 15'h2006;
	localparam logic [14:0] PFSW_CFGW_ADDR   = 15'h2007;
	localparam int          PFSW_CLK_MHZ     = 25;
	localparam int          PFSW_PROG_TIME_US = 2000;
	localparam int          PFSW_PROG_CYCLES = PFSW_PROG_TIME_US * PFSW_CLK_MHZ;
	localparam int          PFSW_NOP_CYCLES  = 2;
	localparam logic [15:0] PFSW_CNT_W1      = 16'h0001;
	typedef enum logic [1:0] {
		PFSW_IDLE,
		PFSW_KEY1,
		PFSW_KEY2
	} pfsw_unlock_t;
	typedef enum logic [1:0] {
		PFSW_READY,
		PFSW_FORCE_NOP,
		PFSW_PROGRAM
	} pfsw_op_t;
endpackage

// >>> design/pfsw_latch_if.sv
// Interface carrying latch loads and row snapshot between top and bank.
// Assumes both ends share mclk_in.
`timescale 1ns/10ps
`default_nettype none
interface pfsw_latch_if;
	import pfsw_pkg::*;
	logic                        load;
	logic [PFSW_LATCH_SEL_W-1:0] sel;
	logic [PFSW_DATA_W-1:0]      wdata;
	logic                        blank_all;
	logic [PFSW_DATA_W-1:0]      word [PFSW_LATCHES];
	modport ctrl (output load, output sel, output wdata, output blank_all,
		input word);
	modport bank (input load, input sel, input wdata, input blank_all,
		output word);
endinterface
`default_nettype wire

// >>> design/pfsw_latch_bank.sv
// Sixteen write latches with per-word load and bulk blanking.
// Assumes load and blank_all come from logic on the same clock.
`timescale 1ns/10ps
`default_nettype none
module pfsw_latch_bank
	import pfsw_pkg::*;
(
	// Clock and reset.
	input  wire logic mclk_in,
	input  wire logic sys_rst_in,
	// Latch port.
	pfsw_latch_if.bank lb
);
	genvar gi;
	generate
		for (gi = 0; gi < PFSW_LATCHES; gi++) begin : g_lat
			logic [PFSW_DATA_W-1:0] word;
			wire                    hit = lb.load &&
				(lb.sel == PFSW_LATCH_SEL_W'(gi));
			always_ff @(posedge mclk_in) begin
				if (sys_rst_in || lb.blank_all)
					word <= PFSW_BLANK_WORD;
				else if (hit)
					word <= lb.wdata;
			end
			assign lb.word[gi] = word;
		end
	endgenerate
endmodule
`default_nettype wire

// >>> design/pfsw_ctrl.sv
// Program flash self-write controller: unlock, latch load, row program.
// Assumes software strobes from the core on mclk_in; flash array outside.
`timescale 1ns/10ps
`default_nettype none
module pfsw_ctrl
	import pfsw_pkg::*;
#(
	parameter int PROG_CYCLES = PFSW_PROG_CYCLES
) (
	// Clock and reset.
	input  wire logic                   mclk_in,
	input  wire logic                   sys_rst_in,
	// Software register strobes and values.
	input  wire logic [PFSW_ADDR_W-1:0] flash_address_in,
	input  wire logic [PFSW_DATA_W-1:0] flash_data_in,
	input  wire logic                   program_enable_in,
	input  wire logic                   config_space_select_in,
	input  wire logic                   latch_only_select_in,
	input  wire logic                   unlock_wr_in,
	input  wire logic [7:0]             unlock_data_in,
	input  wire logic                   start_set_in,
	input  wire logic                   other_access_in,
	input  wire logic                   read_req_in,
	input  wire logic                   error_clr_in,
	// Flash array read data.
	input  wire logic [PFSW_DATA_W-1:0] array_rdata_in,
	// Status to software.
	output logic                        write_start_out,
	output logic                        sequence_error_flag_out,
	output logic                        cpu_stall_out,
	output logic [PFSW_DATA_W-1:0]      flash_data_read_out,
	// Flash array program port.
	output logic                        array_prog_out,
	output logic                        array_cfg_out,
	output logic [PFSW_ADDR_W-1:0]      array_row_addr_out,
	output logic [PFSW_LATCHES*PFSW_DATA_W-1:0] array_prog_data_out
);
	pfsw_latch_if lat ();
	pfsw_latch_bank u_bank (
		.mclk_in    (mclk_in),
		.sys_rst_in (sys_rst_in),
		.lb         (lat.bank)
	);

	localparam logic [15:0] PROG_CNT = PROG_CYCLES[15:0] == 16'h0000 ?
		PFSW_CNT_W1 : PROG_CYCLES[15:0];

	// Write access rights in config space: user IDs only.
	function automatic logic cfg_writable(input logic [PFSW_ADDR_W-1:0] a);
		cfg_writable = (a >= PFSW_CFG_BASE) && (a <= PFSW_UID_LAST);
	endfunction
	function automatic logic cfg_readable(input logic [PFSW_ADDR_W-1:0] a);
		cfg_readable = cfg_writable(a) || (a == PFSW_DEVID_ADDR) ||
			(a == PFSW_CFGW_ADDR);
	endfunction

	pfsw_unlock_t unl;
	pfsw_unlock_t next_unl;
	pfsw_op_t     op;
	logic [15:0]  cnt;

	// Key sequence: any other access in between breaks it.
	always_comb begin
		next_unl = unl;
		case (unl)
			PFSW_IDLE:
				if (unlock_wr_in && unlock_data_in == PFSW_UNLOCK_1)
					next_unl = PFSW_KEY1;
			PFSW_KEY1:
				if (unlock_wr_in && unlock_data_in == PFSW_UNLOCK_2)
					next_unl = PFSW_KEY2;
				else if (unlock_wr_in || other_access_in || start_set_in)
					next_unl = PFSW_IDLE;
			PFSW_KEY2:
				if (unlock_wr_in || other_access_in || start_set_in)
					next_unl = PFSW_IDLE;
			default:
				next_unl = PFSW_IDLE;
		endcase
	end

	wire unlocked  = (unl == PFSW_KEY2);
	wire cfg_ok    = !config_space_select_in ||
		cfg_writable(flash_address_in);
	wire accept    = start_set_in && unlocked && program_enable_in &&
		(op == PFSW_READY) && cfg_ok;
	wire do_prog   = accept && !latch_only_select_in;
	wire prog_done = (op == PFSW_PROGRAM) && (cnt == PFSW_CNT_W1);

	// Address low bits pick the latch; upper bits the row.
	assign lat.load      = accept;
	assign lat.sel       = flash_address_in[PFSW_LATCH_SEL_W-1:0];
	assign lat.wdata     = flash_data_in;
	assign lat.blank_all = prog_done;

	// Word held by the addressed latch, watched by the unlock assertion.
	wire [PFSW_DATA_W-1:0] sel_word = lat.word[lat.sel];

	wire [PFSW_DATA_W-1:0] read_word =
		(config_space_select_in && !cfg_readable(flash_address_in)) ?
		'0 : array_rdata_in;

	always_ff @(posedge mclk_in) begin
		if (sys_rst_in)
			unl <= PFSW_IDLE;
		else
			unl <= next_unl;
	end

	always_ff @(posedge mclk_in) begin
		if (sys_rst_in) begin
			op  <= PFSW_READY;
			cnt <= 16'h0000;
		end else begin
			case (op)
				PFSW_READY:
					if (do_prog) begin
						op  <= PFSW_PROGRAM;
						cnt <= PROG_CNT;
					end else if (accept) begin
						op  <= PFSW_FORCE_NOP;
						cnt <= 16'(PFSW_NOP_CYCLES);
					end
				PFSW_FORCE_NOP, PFSW_PROGRAM:
					if (cnt == PFSW_CNT_W1)
						op <= PFSW_READY;
					else
						cnt <= cnt - PFSW_CNT_W1;
				default:
					op <= PFSW_READY;
			endcase
		end
	end

	// Only programs the latched row; erasing is done elsewhere.
	always_ff @(posedge mclk_in) begin
		if (sys_rst_in) begin
			array_prog_out      <= 1'b0;
			array_cfg_out       <= 1'b0;
			array_row_addr_out  <= '0;
			array_prog_data_out <= '0;
		end else begin
			array_prog_out <= do_prog;
			if (do_prog) begin
				array_cfg_out      <= config_space_select_in;
				array_row_addr_out <= {flash_address_in[PFSW_ADDR_W-1:
					PFSW_ROW_LSB], 5'h00};
				for (int i = 0; i < PFSW_LATCHES; i++)
					array_prog_data_out[i*PFSW_DATA_W +: PFSW_DATA_W] <=
						(i == int'(lat.sel)) ? flash_data_in : lat.word[i];
			end
		end
	end

	always_ff @(posedge mclk_in) begin
		if (sys_rst_in) begin
			write_start_out         <= 1'b0;
			sequence_error_flag_out <= 1'b0;
			cpu_stall_out           <= 1'b0;
			flash_data_read_out     <= '0;
		end else begin
			write_start_out <= accept || (op != PFSW_READY && !(
				cnt == PFSW_CNT_W1));
			// The set wins when a start attempt meets a clear.
			if (start_set_in)
				sequence_error_flag_out <= 1'b1;
			else if (error_clr_in)
				sequence_error_flag_out <= 1'b0;
			cpu_stall_out <= do_prog || (op == PFSW_PROGRAM &&
				cnt != PFSW_CNT_W1);
			if (read_req_in)
				flash_data_read_out <= read_word;
		end
	end

	property p_load_needs_unlock;
		@(posedge mclk_in) disable iff (sys_rst_in)
		start_set_in && !unlocked && !prog_done |=>
			lat.word[$past(lat.sel)] == $past(sel_word);
	endproperty
	a_load_needs_unlock: assert property (p_load_needs_unlock)
		else $error("latch load without unlock");
	property p_enable_blocks;
		@(posedge mclk_in) disable iff (sys_rst_in)
		!program_enable_in |-> ##1 !array_prog_out;
	endproperty
	a_enable_blocks: assert property (p_enable_blocks)
		else $error("program started while disabled");
	property p_error_set;
		@(posedge mclk_in) disable iff (sys_rst_in)
		start_set_in |=> sequence_error_flag_out;
	endproperty
	a_error_set: assert property (p_error_set)
		else $error("error flag not set on start attempt");
	property p_latch_only;
		@(posedge mclk_in) disable iff (sys_rst_in)
		accept && latch_only_select_in |=> !array_prog_out && !cpu_stall_out;
	endproperty
	a_latch_only: assert property (p_latch_only)
		else $error("latch-only load started programming");
	property p_prog_start;
		@(posedge mclk_in) disable iff (sys_rst_in)
		do_prog |=> array_prog_out && cpu_stall_out && write_start_out;
	endproperty
	a_prog_start: assert property (p_prog_start)
		else $error("row program not started");
	property p_blank;
		@(posedge mclk_in) disable iff (sys_rst_in)
		prog_done |=> lat.word[0] == PFSW_BLANK_WORD &&
			lat.word[15] == PFSW_BLANK_WORD;
	endproperty
	a_blank: assert property (p_blank)
		else $error("latches not blanked");
	property p_row_align;
		@(posedge mclk_in) disable iff (sys_rst_in)
		array_prog_out |-> array_row_addr_out[4:0] == 5'h00;
	endproperty
	a_row_align: assert property (p_row_align)
		else $error("row address not aligned");
	sequence s_bad_cfg_read;
		read_req_in && config_space_select_in &&
			!cfg_readable(flash_address_in);
	endsequence
	property p_cfg_zero;
		@(posedge mclk_in) disable iff (sys_rst_in)
		s_bad_cfg_read |=> flash_data_read_out == '0;
	endproperty
	a_cfg_zero: assert property (p_cfg_zero)
		else $error("illegal config read not zero");
	property p_ws_clear;
		@(posedge mclk_in) disable iff (sys_rst_in)
		$rose(write_start_out) && !cpu_stall_out |-> ##[1:3] !write_start_out;
	endproperty
	a_ws_clear: assert property (p_ws_clear)
		else $error("write-start not cleared after load");
endmodule
`default_nettype wire

// >>> test/pfsw_flash_model.sv
// Behavioural model of the program flash array behind the controller.
// Assumes program pulses and row data come from the controller on mclk_in.
`timescale 1ns/10ps
`default_nettype none
module pfsw_flash_model
	import pfsw_pkg::*;
#(
	// Identification value is arbitrary.
	parameter logic [13:0] DEVID = 14'h0123
) (
	// Clock.
	input  wire logic                   mclk_in,
	// Read side.
	input  wire logic [PFSW_ADDR_W-1:0] addr_in,
	input  wire logic                   cfg_in,
	output logic [PFSW_DATA_W-1:0]      rdata_out,
	// Program side.
	input  wire logic                   prog_in,
	input  wire logic                   prog_cfg_in,
	input  wire logic [PFSW_ADDR_W-1:0] row_in,
	input  wire logic [PFSW_LATCHES*PFSW_DATA_W-1:0] data_in
);
	logic [13:0] main_mem [512];
	logic [13:0] cfg_mem  [8];
	initial begin
		// Software only erases whole rows, so the array starts as erased rows.
		foreach (main_mem[i]) main_mem[i] = PFSW_BLANK_WORD;
		foreach (cfg_mem[i]) cfg_mem[i] = PFSW_BLANK_WORD;
		cfg_mem[6] = DEVID;
	end
	assign rdata_out = cfg_in ? cfg_mem[addr_in[2:0]] :
		main_mem[addr_in[8:0]];
	// Programming only clears bits, so a word must be blank beforehand.
	always @(posedge mclk_in) begin
		if (prog_in === 1'b1) begin
			for (int i = 0; i < PFSW_LATCHES; i++) begin
				if (prog_cfg_in) begin
					if (i < 4) cfg_mem[i] &= data_in[i*14 +: 14];
				end else begin
					main_mem[row_in[8:0] + i] &= data_in[i*14 +: 14];
				end
			end
		end
	end
endmodule
`default_nettype wire

// >>> test/tb_pfsw_ctrl.sv
// Self-checking bench for the flash self-write controller.
// Assumes the controller drives a behavioural flash array model.
`timescale 1ns/10ps
`default_nettype none
module tb_pfsw_ctrl
	import pfsw_pkg::*;
;
	localparam logic [13:0] DEVID = 14'h0123;
	logic mclk_in = 0, sys_rst_in = 1;
	logic [14:0] flash_address_in = 0, array_row_addr_out;
	logic [13:0] flash_data_in = 0, array_rdata_in, flash_data_read_out;
	logic program_enable_in = 0, config_space_select_in = 0;
	logic latch_only_select_in = 0, unlock_wr_in = 0, start_set_in = 0;
	logic other_access_in = 0, read_req_in = 0, error_clr_in = 0;
	logic [7:0] unlock_data_in = 0;
	logic write_start_out, sequence_error_flag_out, cpu_stall_out;
	logic array_prog_out, array_cfg_out;
	logic [223:0] array_prog_data_out, ex;
	int err_total = 0, total_checks = 0, prog_cnt = 0;
	logic stalled, busy;
	initial forever #20 mclk_in = ~mclk_in;
	pfsw_ctrl #(.PROG_CYCLES(8)) i_pfsw_ctrl (.mclk_in(mclk_in),
		.sys_rst_in(sys_rst_in), .flash_address_in(flash_address_in),
		.flash_data_in(flash_data_in), .program_enable_in(program_enable_in),
		.config_space_select_in(config_space_select_in),
		.latch_only_select_in(latch_only_select_in),
		.unlock_wr_in(unlock_wr_in), .unlock_data_in(unlock_data_in),
		.start_set_in(start_set_in), .other_access_in(other_access_in),
		.read_req_in(read_req_in), .error_clr_in(error_clr_in),
		.array_rdata_in(array_rdata_in), .write_start_out(write_start_out),
		.sequence_error_flag_out(sequence_error_flag_out),
		.cpu_stall_out(cpu_stall_out),
		.flash_data_read_out(flash_data_read_out),
		.array_prog_out(array_prog_out), .array_cfg_out(array_cfg_out),
		.array_row_addr_out(array_row_addr_out),
		.array_prog_data_out(array_prog_data_out));
	pfsw_flash_model #(.DEVID(DEVID)) i_pfsw_flash_model (.mclk_in(mclk_in),
		.addr_in(flash_address_in), .cfg_in(config_space_select_in),
		.rdata_out(array_rdata_in), .prog_in(array_prog_out),
		.prog_cfg_in(array_cfg_out), .row_in(array_row_addr_out),
		.data_in(array_prog_data_out));
	always @(posedge mclk_in) if (array_prog_out === 1'b1) prog_cnt++;
	task automatic final_report;
		$display("checks %0d mismatches %0d", total_checks, err_total);
		if (err_total == 0 && total_checks > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic chk(input logic [223:0] g, input logic [223:0] e);
		total_checks++;
		if (g !== e) begin
			err_total++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	// One load or program attempt; brk slips a foreign access into the keys.
	task automatic seq(input logic [14:0] a, input logic [13:0] d,
		input logic lo, input logic brk);
		int n;
		@(posedge mclk_in);
		flash_address_in <= a;
		flash_data_in <= d;
		latch_only_select_in <= lo;
		unlock_wr_in <= 1'b1;
		unlock_data_in <= PFSW_UNLOCK_1;
		@(posedge mclk_in);
		unlock_wr_in <= ~brk;
		other_access_in <= brk;
		unlock_data_in <= PFSW_UNLOCK_2;
		if (brk) begin
			@(posedge mclk_in);
			other_access_in <= 1'b0;
			unlock_wr_in <= 1'b1;
		end
		@(posedge mclk_in);
		unlock_wr_in <= 1'b0;
		start_set_in <= 1'b1;
		@(posedge mclk_in);
		start_set_in <= 1'b0;
		stalled = 0;
		busy = 0;
		n = 0;
		do begin
			@(posedge mclk_in);
			#1;
			stalled |= cpu_stall_out;
			busy |= write_start_out;
			n++;
		end while ((n < 2 || write_start_out !== 1'b0) && n < 50);
		if (n >= 50) begin
			err_total++;
			final_report();
		end
	endtask
	task automatic rd(input logic [14:0] a, input logic [13:0] e);
		@(posedge mclk_in);
		flash_address_in <= a;
		read_req_in <= 1'b1;
		@(posedge mclk_in);
		read_req_in <= 1'b0;
		#1 chk(flash_data_read_out, e);
	endtask
	initial begin
		repeat (8) @(posedge mclk_in);
		sys_rst_in <= 1'b0;
		program_enable_in <= 1'b1;
		seq(15'h0043, 14'h0111, 1'b1, 1'b0);
		chk(prog_cnt, 0);
		chk({busy, stalled}, 2'b10);
		seq(15'h004f, 14'h0222, 1'b0, 1'b0);
		ex = {16{PFSW_BLANK_WORD}};
		ex[3*14 +: 14] = 14'h0111;
		ex[15*14 +: 14] = 14'h0222;
		chk(array_prog_data_out, ex);
		chk(array_row_addr_out, 15'h0040);
		chk(prog_cnt, 1);
		chk({stalled, sequence_error_flag_out}, 2'b11);
		rd(15'h0043, 14'h0111);
		rd(15'h004f, 14'h0222);
		$display("test latch load and row program done");
		seq(15'h0081, 14'h0333, 1'b1, 1'b1);
		seq(15'h0082, 14'h0444, 1'b0, 1'b0);
		ex = {16{PFSW_BLANK_WORD}};
		ex[2*14 +: 14] = 14'h0444;
		chk(array_prog_data_out, ex);
		chk(array_row_addr_out, 15'h0080);
		$display("test broken unlock and blanking done");
		@(posedge mclk_in) error_clr_in <= 1'b1;
		@(posedge mclk_in) error_clr_in <= 1'b0;
		@(posedge mclk_in) #1 chk(sequence_error_flag_out, 0);
		@(posedge mclk_in) start_set_in <= 1'b1;
		@(posedge mclk_in) start_set_in <= 1'b0;
		repeat (3) @(posedge mclk_in);
		#1 chk(prog_cnt, 2);
		chk(sequence_error_flag_out, 1);
		@(posedge mclk_in) program_enable_in <= 1'b0;
		seq(15'h00c0, 14'h0555, 1'b0, 1'b0);
		chk(prog_cnt, 2);
		$display("test refused starts done");
		@(posedge mclk_in);
		program_enable_in <= 1'b1;
		config_space_select_in <= 1'b1;
		seq(15'h2001, 14'h0555, 1'b0, 1'b0);
		chk({prog_cnt[1:0], array_cfg_out}, 3'b111);
		chk(array_row_addr_out, 15'h2000);
		seq(15'h2007, 14'h0000, 1'b0, 1'b0);
		chk(prog_cnt, 3);
		rd(15'h2001, 14'h0555);
		rd(15'h2006, DEVID);
		rd(15'h2007, PFSW_BLANK_WORD);
		rd(15'h2004, 14'h0000);
		@(posedge mclk_in) config_space_select_in <= 1'b0;
		rd(15'h0082, 14'h0444);
		$display("test configuration space done");
		final_report();
	end
endmodule
`default_nettype wire
